//--- logic/asrc_host.sv
// Function
// - write strobe asserted only while both selects are active
// - raising the write strobe ends the write; data taken no later
// - write data stable 15 ns before and 0 ns after write end
// - write strobe held high for the whole read cycle
// - address valid no later than selects assert on a write
// - address held 20 ns before write end; strobe low 20 ns; cycle 25 ns
// - address may change at write end; zero setup before write
`timescale 1ns/10ps
`default_nettype none
module asrc_host
	import asrc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire asrc_req_t i_req,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [DATA_W-1:0] o_rsp_data,
	output asrc_pins_t o_pins,
	input wire logic [DATA_W-1:0] i_data_pins,
	output logic [DATA_W-1:0] o_data_pins,
	output logic o_data_pins_oe
);
	asrc_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	asrc_pins_t pins_ff, nxt_pins;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic doe_ff, nxt_doe;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic rsp_ff, nxt_rsp;
	logic [DATA_W-1:0] sync1_ff, sync2_ff;
	logic take_req;
	logic take_wr;
	logic take_rd;
	logic cnt_last;
	logic wr_done;
	logic rd_done;

	localparam asrc_pins_t PINS_IDLE = '{address_pins: '0, select_n_primary: 1'b1,
		select_active_high: 1'b0, oe_n: 1'b1, we_n: 1'b1};
	localparam int SYNC_STAGES = 2;
	// strobe low long enough for pulse width, address and data setup
	localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WRITE_PULSE_CYC > DATA_SETUP_CYC
		? WRITE_PULSE_CYC : DATA_SETUP_CYC);
	// access time plus the input synchroniser
	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(READ_WAIT_CYC + SYNC_STAGES);

	// data pins pass two flops before any logic reads them
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= i_data_pins;
			sync2_ff <= sync1_ff;
		end
	end

	// requests are taken in idle only
	assign take_req = i_req_valid && (state_ff == ST_IDLE);
	assign take_wr = take_req && i_req.write;
	assign take_rd = take_req && !i_req.write;
	assign cnt_last = (cnt_ff == CNT_W'(1));
	assign wr_done = (state_ff == ST_WRITE) && cnt_last;
	assign rd_done = (state_ff == ST_READ) && cnt_last;

	// sequencer: state and access length counter
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take_wr) begin
					nxt_cnt = WR_LOAD;
					nxt_state = ST_WRITE;
				end else if (take_rd) begin
					nxt_cnt = RD_LOAD;
					nxt_state = ST_READ;
				end
			end
			ST_READ: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_last) begin
					nxt_state = ST_RECOV;
				end
			end
			ST_WRITE: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_last) begin
					nxt_state = ST_RECOV;
				end
			end
			ST_RECOV: begin
				// one idle cycle turns the data bus round
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// pin group: address, selects and strobes
	always_comb begin
		nxt_pins = pins_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take_req) begin
					// address and selects go out together, zero setup
					nxt_pins.address_pins = i_req.addr;
					nxt_pins.select_n_primary = 1'b0;
					nxt_pins.select_active_high = 1'b1;
					nxt_pins.oe_n = i_req.write;
					nxt_pins.we_n = !i_req.write;
				end
			end
			ST_READ: begin
				if (cnt_last) begin
					nxt_pins = PINS_IDLE;
				end
			end
			ST_WRITE: begin
				if (cnt_last) begin
					// strobe rises and both selects go inactive together, ending the write
					nxt_pins.we_n = 1'b1;
					nxt_pins.select_n_primary = 1'b1;
					nxt_pins.select_active_high = 1'b0;
				end
			end
			ST_RECOV: begin
				nxt_pins = PINS_IDLE;
			end
			default: begin
				nxt_pins = PINS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pins_ff <= PINS_IDLE;
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	// write data and its drive enable
	always_comb begin
		nxt_wdata = wdata_ff;
		nxt_doe = doe_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take_wr) begin
					nxt_wdata = i_req.wdata;
					nxt_doe = 1'b1;
				end else if (take_rd) begin
					nxt_doe = 1'b0;
				end
			end
			ST_READ, ST_WRITE: begin
				// data stays until the cycle after the strobe rises
				nxt_doe = doe_ff;
			end
			ST_RECOV: begin
				nxt_doe = 1'b0;
			end
			default: begin
				nxt_doe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wdata_ff <= '0;
			doe_ff <= 1'b0;
		end else begin
			wdata_ff <= nxt_wdata;
			doe_ff <= nxt_doe;
		end
	end

	// answer: read data from the synchroniser, one-cycle valid pulse
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_rsp = 1'b0;
		if (rd_done) begin
			nxt_rdata = sync2_ff;
			nxt_rsp = 1'b1;
		end else if (wr_done) begin
			nxt_rsp = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= '0;
			rsp_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rsp_ff <= nxt_rsp;
		end
	end

	assign o_req_ready = (state_ff == ST_IDLE);
	assign o_rsp_valid = rsp_ff;
	assign o_rsp_data = rdata_ff;
	assign o_pins = pins_ff;
	assign o_data_pins = wdata_ff;
	assign o_data_pins_oe = doe_ff;
endmodule
`default_nettype wire

//--- pkg/asrc_pkg.sv
`default_nettype none
package asrc_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 9;
	localparam int CLK_PERIOD_NS = 40;
	// device timing, fastest grade, in ns
	localparam int READ_CYCLE_MIN_NS = 25;
	localparam int ADDRESS_ACCESS_DELAY_NS = 25;
	localparam int OUTPUT_HOLD_AFTER_ADDRESS_NS = 3;
	localparam int WRITE_CYCLE_MIN_NS = 25;
	localparam int WRITE_PULSE_MIN_NS = 20;
	localparam int ADDRESS_TO_WRITE_END_NS = 20;
	localparam int DATA_SETUP_TO_WRITE_END_NS = 15;
	localparam int DATA_HOLD_AFTER_WRITE_END_NS = 0;
	localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
	localparam int ADDRESS_SETUP_BEFORE_WRITE_NS = 0;
	// least times round up, at least one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int READ_WAIT_CYC = cyc_min(ADDRESS_ACCESS_DELAY_NS) > cyc_min(READ_CYCLE_MIN_NS)
		? cyc_min(ADDRESS_ACCESS_DELAY_NS) : cyc_min(READ_CYCLE_MIN_NS);
	localparam int WRITE_PULSE_CYC = cyc_min(WRITE_PULSE_MIN_NS) > cyc_min(ADDRESS_TO_WRITE_END_NS)
		? cyc_min(WRITE_PULSE_MIN_NS) : cyc_min(ADDRESS_TO_WRITE_END_NS);
	localparam int DATA_SETUP_CYC = cyc_min(DATA_SETUP_TO_WRITE_END_NS);
	localparam int CNT_W = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
	} asrc_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address_pins;
		logic select_n_primary;
		logic select_active_high;
		logic oe_n;
		logic we_n;
	} asrc_pins_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WRITE = 4'h4,
		ST_RECOV = 4'h8
	} asrc_state_t;
endpackage
`default_nettype wire

//--- testbench/asrc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_checker
	import asrc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire asrc_req_t i_req,
	input wire logic o_req_ready,
	input wire logic o_rsp_valid,
	input wire asrc_pins_t o_pins,
	input wire logic [DATA_W-1:0] o_data_pins,
	input wire logic o_data_pins_oe
);
	wire we = !o_pins.we_n;
	wire rd = !o_pins.oe_n;
	wire sel = !o_pins.select_n_primary && o_pins.select_active_high;
	wire tk = i_req_valid && o_req_ready;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_we_sel: assert property (we |-> sel) else $error("strobe unselected");
	a_wr_end: assert property (we |=> !we && !sel ##1 !we) else $error("write end");
	a_data_hold: assert property ($rose(o_pins.we_n) |-> $stable(o_data_pins)
		&& o_data_pins_oe ##1 !o_data_pins_oe) else $error("data hold");
	a_wr_start: assert property (tk && i_req.write |=> we && o_data_pins_oe
		&& o_pins.address_pins == $past(i_req.addr) && o_data_pins == $past(i_req.wdata))
		else $error("write start");
	a_addr_hold: assert property (we |=> $stable(o_pins.address_pins)) else $error("wa");
	a_rsp_desel: assert property (o_rsp_valid |-> !sel && o_pins.we_n) else $error("end");
	a_rd_we: assert property (rd |-> !we && sel && !o_data_pins_oe) else $error("read");
	a_rd_addr: assert property (rd ##1 rd |-> $stable(o_pins.address_pins)) else $error("ra");
	a_rd_rsp: assert property (tk && !i_req.write |=> rd ##3 o_rsp_valid) else $error("rsp");
endmodule
bind asrc_host asrc_checker u_asrc_checker (.i_clk(i_clk), .i_rst(i_rst),
	.i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
	.o_rsp_valid(o_rsp_valid), .o_pins(o_pins), .o_data_pins(o_data_pins),
	.o_data_pins_oe(o_data_pins_oe));
`default_nettype wire

//--- testbench/asrc_sram_model.sv
`timescale 1ns/10ps
`default_nettype none
module asrc_sram_model
	import asrc_pkg::*;
(
	input wire asrc_pins_t i_pins,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic i_data_oe,
	output logic [DATA_W-1:0] o_data
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] q = '0;
	wire sel = !i_pins.select_n_primary && i_pins.select_active_high;
	wire drv = sel && !i_pins.oe_n && i_pins.we_n;
	always @* if (sel && !i_pins.we_n) mem[i_pins.address_pins] = i_data;
	// floating bus shows the inverse of the last value
	always @(i_pins.address_pins, drv) q <= #25 drv ? mem[i_pins.address_pins] : ~q;
	assign o_data = i_data_oe ? i_data : q;
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import asrc_pkg::*;
	logic i_clk = 0, i_rst = 1, i_req_valid = 0, o_req_ready, o_rsp_valid, oe;
	asrc_req_t i_req = '0;
	logic [DATA_W-1:0] o_rsp_data, dout, din, r;
	asrc_pins_t o_pins;
	int err_total = 0, comparisons = 0, cyc = 0, n;
	asrc_host u_asrc_host (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
		.o_rsp_data(o_rsp_data), .o_pins(o_pins), .i_data_pins(din), .o_data_pins(dout),
		.o_data_pins_oe(oe));
	asrc_sram_model u_asrc_sram_model (.i_pins(o_pins), .i_data(dout), .i_data_oe(oe),
		.o_data(din));
	initial forever #20 i_clk = ~i_clk;
	always @(posedge i_clk) if (++cyc == 3000) begin
		err_total++;
		wrap_up();
	end
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// starts and ends just after a rising edge
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		while (o_req_ready !== 1'b1) @(posedge i_clk) #1;
		i_req_valid = 1;
		i_req = {a, d, wr};
		@(posedge i_clk) #1;
		i_req_valid = 0;
		for (n = 0; n < 9 && o_rsp_valid !== 1'b1; n++) @(posedge i_clk) #1;
		chk(n[DATA_W-1:0], wr ? 9'h001 : 9'h003);
		r = o_rsp_data;
	endtask
	task automatic t_idle();
		chk({o_pins.select_n_primary, o_pins.select_active_high, o_pins.we_n, o_pins.oe_n, oe},
			9'h016);
		$display("test idle done");
	endtask
	task automatic t_wr_rd();
		logic [ADDR_W-1:0] a [4] = '{13'h0000, 13'h1fff, 13'h0000, 13'h00a5};
		logic [DATA_W-1:0] d [4] = '{9'h1ff, 9'h000, 9'h0aa, 9'h155};
		for (int i = 0; i < 4; i++) xfer(1'b1, a[i], d[i]);
		for (int i = 1; i < 4; i++) begin
			xfer(1'b0, a[i], 9'h000);
			chk(r, d[i]);
		end
		$display("test write read done");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		#1 i_rst = 0;
		t_idle();
		t_wr_rd();
		wrap_up();
	end
endmodule
`default_nettype wire
